// file: hdl/isc_core.v
// Input scaler: normalise a current sample and apply the conversion characteristic
`include "isc_defines.vh"
module isc_core #(
    parameter SW = 16,
    parameter FD = 4
) (
    // Clock and reset
    input  wire          i_clk,
    input  wire          i_rst_b,
    // Register port
    input  wire [7:0]    i_addr,
    input  wire [15:0]   i_wdata,
    input  wire          i_wr,
    input  wire          i_rd,
    output reg  [15:0]   o_rdata,
    // Sample input, signed microamps
    input  wire          i_smp_valid,
    input  wire [SW-1:0] i_smp_data,
    output wire          o_smp_ready,
    // Display result
    output wire          o_res_valid,
    output wire [15:0]   o_res_data,
    input  wire          i_res_ready
);
    localparam S_IDLE = 7'h01;
    localparam S_NDIV = 7'h02;
    localparam S_SHP  = 7'h04;
    localparam S_ROOT = 7'h08;
    localparam S_SCL  = 7'h10;
    localparam S_UDIV = 7'h20;
    localparam S_PUSH = 7'h40;

    // Round a Q16 value to integer and saturate to the display range
    function [15:0] sat_rnd;
        input signed [63:0] v;
        input signed [15:0] add;
        reg signed [63:0] r;
        begin
            // Kept signed throughout, or the shift turns logical for negatives
            r = v + $signed(`ISC_HALF);
            r = (r >>> 16) + $signed({{48{add[15]}}, add});
            if (r < $signed({{48{1'b1}}, `ISC_W_MIN}))
                sat_rnd = `ISC_W_MIN;
            else if (r > $signed({48'h0, `ISC_W_MAX}))
                sat_rnd = `ISC_W_MAX;
            else
                sat_rnd = r[15:0];
        end
    endfunction

    // Configuration
    reg [2:0]  ctrl_r;
    reg [15:0] loc_r;
    reg [15:0] hic_r;
    reg [4:0]  npts_r;
    reg [15:0] svc_r;
    reg [15:0] px_r [0:19];
    reg [15:0] py_r [0:19];
    reg        prompt_r;
    reg        svc_open_r;
    // Datapath
    reg [6:0]  st_r;
    reg [31:0] n_r;
    reg [31:0] shp_r;
    reg [15:0] res_r;
    reg [15:0] last_r;
    reg [63:0] dv_a_r;
    reg [31:0] dv_r_r;
    reg [31:0] dv_d_r;
    reg [6:0]  dv_n_r;
    reg        dv_neg_r;
    reg        sq_go_r;
    reg [4:0]  seg;
    integer    i;
    integer    j;

    wire        fifo_in_ready;
    wire [19:0] sq_root;
    wire        sq_done;
    wire [1:0]  mode = ctrl_r[`ISC_F_MODE];
    wire        r420 = ctrl_r[`ISC_F_RANGE];
    wire [15:0] start = r420 ? `ISC_START_420 : `ISC_START_020;
    wire [15:0] span  = r420 ? `ISC_SPAN_420 : `ISC_SPAN_020;

    // Offset correction with service trim, two extra bits against overflow
    wire signed [17:0] xc = {{(18-SW){i_smp_data[SW-1]}}, i_smp_data}
                          - {2'b00, start}
                          + {{2{svc_r[15]}}, svc_r};
    wire signed [63:0] nnum = {{30{xc[17]}}, xc, 16'h0000};

    wire signed [31:0] n_s   = n_r;
    wire signed [63:0] n_sq  = n_s * n_s;
    wire        [63:0] sq_rnd = n_sq + `ISC_HALF;
    wire signed [16:0] dif   = {hic_r[15], hic_r} - {loc_r[15], loc_r};
    wire signed [31:0] shp_s = shp_r;
    wire signed [63:0] scl_p = shp_s * dif;
    wire signed [63:0] np    = n_s * $signed(`ISC_PCT10);

    // Segment choice: last point at or below the percent, clamped to the ends
    always @* begin
        seg = 5'h00;
        for (i = 1; i < 19; i = i + 1) begin
            if ((i < npts_r - 1) &&
                (np >= $signed({{32{px_r[i][15]}}, px_r[i], 16'h0000})))
                seg = i[4:0];
        end
    end

    wire [15:0] xl = px_r[seg];
    wire [15:0] xh = px_r[seg + 5'h01];
    wire [15:0] yl = py_r[seg];
    wire [15:0] yh = py_r[seg + 5'h01];
    wire signed [16:0] dx = {xh[15], xh} - {xl[15], xl};
    wire signed [16:0] dy = {yh[15], yh} - {yl[15], yl};
    wire signed [63:0] uoff = np - {{32{xl[15]}}, xl, 16'h0000};
    wire signed [63:0] unum = uoff * dy;

    wire        dv_busy = (dv_n_r != 7'h00);
    wire [63:0] dv_q    = dv_neg_r ? (~dv_a_r + 64'h1) : dv_a_r;
    wire [32:0] dv_t    = {dv_r_r, dv_a_r[63]};
    wire        dv_ge   = (dv_t >= {1'b0, dv_d_r});

    wire in_tab_x = (i_addr >= `ISC_A_PTX) && (i_addr < `ISC_A_PTX + `ISC_NPT_MAX);
    wire in_tab_y = (i_addr >= `ISC_A_PTY) && (i_addr < `ISC_A_PTY + `ISC_NPT_MAX);
    wire [7:0] tx = i_addr - `ISC_A_PTX;
    wire [7:0] ty = i_addr - `ISC_A_PTY;

    assign o_smp_ready = (st_r == S_IDLE);

    // Configuration registers and access codes
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl_r     <= `ISC_RST_CTRL;
            loc_r      <= `ISC_RST_LOC;
            hic_r      <= `ISC_RST_HIC;
            npts_r     <= `ISC_RST_NPTS;
            svc_r      <= `ISC_RST_SVC;
            prompt_r   <= 1'b0;
            svc_open_r <= 1'b0;
            for (j = 0; j < 20; j = j + 1) begin
                px_r[j] <= (j == 1) ? `ISC_RST_XHI : 16'h0000;
                py_r[j] <= (j == 1) ? `ISC_RST_YHI : 16'h0000;
            end
        end else if (i_wr) begin
            case (i_addr)
                `ISC_A_CTRL: ctrl_r <= i_wdata[2:0];
                `ISC_A_LOC:  loc_r <= i_wdata;
                `ISC_A_HIC:  hic_r <= i_wdata;
                `ISC_A_NPTS: begin
                    // Counts outside 2 .. 20 are pulled to the nearest limit
                    if (i_wdata < 16'h0002)
                        npts_r <= 5'h02;
                    else if (i_wdata > 16'h0014)
                        npts_r <= 5'h14;
                    else
                        npts_r <= i_wdata[4:0];
                end
                `ISC_A_KEY: begin
                    prompt_r   <= (i_wdata == `ISC_KEY_FACTORY_DEFAULTS_OPTION);
                    svc_open_r <= (i_wdata == `ISC_KEY_SVC);
                end
                `ISC_A_CMD: begin
                    if (prompt_r && i_wdata[`ISC_F_ENTER]) begin
                        ctrl_r   <= `ISC_RST_CTRL;
                        loc_r    <= `ISC_RST_LOC;
                        hic_r    <= `ISC_RST_HIC;
                        npts_r   <= `ISC_RST_NPTS;
                        svc_r    <= `ISC_RST_SVC;
                        prompt_r <= 1'b0;
                        for (j = 0; j < 20; j = j + 1) begin
                            px_r[j] <= (j == 1) ? `ISC_RST_XHI : 16'h0000;
                            py_r[j] <= (j == 1) ? `ISC_RST_YHI : 16'h0000;
                        end
                    end else if (prompt_r && i_wdata[`ISC_F_ESCAPE]) begin
                        prompt_r <= 1'b0;
                    end
                end
                `ISC_A_SVC: begin
                    if (svc_open_r)
                        svc_r <= i_wdata;
                end
                default: begin
                    if (in_tab_x)
                        px_r[tx[4:0]] <= i_wdata;
                    if (in_tab_y)
                        py_r[ty[4:0]] <= i_wdata;
                end
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                `ISC_A_CTRL: o_rdata <= {13'h0000, ctrl_r};
                `ISC_A_LOC:  o_rdata <= loc_r;
                `ISC_A_HIC:  o_rdata <= hic_r;
                `ISC_A_NPTS: o_rdata <= {11'h000, npts_r};
                `ISC_A_STAT: o_rdata <= {12'h000, o_res_valid, svc_open_r, prompt_r,
                                         (st_r != S_IDLE)};
                `ISC_A_SVC:  o_rdata <= svc_r;
                `ISC_A_LAST: o_rdata <= last_r;
                default: begin
                    if (in_tab_x)
                        o_rdata <= px_r[tx[4:0]];
                    else if (in_tab_y)
                        o_rdata <= py_r[ty[4:0]];
                    else
                        o_rdata <= 16'h0000;
                end
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // Conversion sequence with one shared restoring divider
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_r     <= S_IDLE;
            n_r      <= 32'h0;
            shp_r    <= 32'h0;
            res_r    <= 16'h0000;
            last_r   <= 16'h0000;
            dv_a_r   <= 64'h0;
            dv_r_r   <= 32'h0;
            dv_d_r   <= 32'h1;
            dv_n_r   <= 7'h00;
            dv_neg_r <= 1'b0;
            sq_go_r  <= 1'b0;
        end else begin
            sq_go_r <= 1'b0;
            if (dv_busy) begin
                dv_r_r <= dv_ge ? (dv_t[31:0] - dv_d_r) : dv_t[31:0];
                dv_a_r <= {dv_a_r[62:0], dv_ge};
                dv_n_r <= dv_n_r - 7'h01;
            end
            case (st_r)
                S_IDLE: begin
                    if (i_smp_valid) begin
                        // Half the divisor is added first so the quotient rounds
                        dv_a_r   <= (nnum[63] ? -nnum : nnum) + {48'h0, span[15:1]};
                        dv_d_r   <= {16'h0, span};
                        dv_r_r   <= 32'h0;
                        dv_neg_r <= nnum[63];
                        dv_n_r   <= 7'h40;
                        st_r     <= S_NDIV;
                    end
                end
                S_NDIV: begin
                    if (!dv_busy) begin
                        n_r  <= dv_q[31:0];
                        st_r <= S_SHP;
                    end
                end
                S_SHP: begin
                    case (mode)
                        `ISC_M_SQR: begin
                            shp_r <= sq_rnd[47:16];
                            st_r  <= S_SCL;
                        end
                        `ISC_M_ROOT: begin
                            if (n_s < 0) begin
                                res_r <= loc_r;
                                st_r  <= S_PUSH;
                            end else begin
                                sq_go_r <= 1'b1;
                                st_r    <= S_ROOT;
                            end
                        end
                        `ISC_M_USER: begin
                            if (dx <= 0) begin
                                res_r <= yl;
                                st_r  <= S_PUSH;
                            end else begin
                                dv_a_r   <= (unum[63] ? -unum : unum)
                                          + {48'h0, dx[15:1]};
                                dv_d_r   <= {16'h0, dx[15:0]};
                                dv_r_r   <= 32'h0;
                                dv_neg_r <= unum[63];
                                dv_n_r   <= 7'h40;
                                st_r     <= S_UDIV;
                            end
                        end
                        default: begin
                            shp_r <= n_r;
                            st_r  <= S_SCL;
                        end
                    endcase
                end
                S_ROOT: begin
                    if (sq_done) begin
                        shp_r <= {12'h000, sq_root};
                        st_r  <= S_SCL;
                    end
                end
                S_SCL: begin
                    res_r <= sat_rnd(scl_p, loc_r);
                    st_r  <= S_PUSH;
                end
                S_UDIV: begin
                    if (!dv_busy) begin
                        res_r <= sat_rnd(dv_q, yl);
                        st_r  <= S_PUSH;
                    end
                end
                S_PUSH: begin
                    // Held here while the FIFO is full, so samples are refused
                    if (fifo_in_ready) begin
                        last_r <= res_r;
                        st_r   <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    isc_sqrt #(
        .W (40)
    ) u_sqrt (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_start (sq_go_r),
        .i_rad   ({n_r[23:0], 16'h0000}),
        .o_root  (sq_root),
        .o_done  (sq_done)
    );

    isc_fifo #(
        .W  (16),
        .D  (FD),
        .AW (2)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (st_r == S_PUSH),
        .i_in_data   (res_r),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (o_res_valid),
        .o_out_data  (o_res_data),
        .i_out_ready (i_res_ready)
    );
endmodule // isc_core

// file: hdl/isc_defines.vh
// Register map, field positions, reset values and constants of the input scaler
`ifndef ISC_DEFINES_VH
`define ISC_DEFINES_VH
// Word addresses on the register port
`define ISC_A_CTRL   8'h00
`define ISC_A_LOC    8'h01
`define ISC_A_HIC    8'h02
`define ISC_A_NPTS   8'h03
`define ISC_A_KEY    8'h04
`define ISC_A_CMD    8'h05
`define ISC_A_STAT   8'h06
`define ISC_A_SVC    8'h07
`define ISC_A_LAST   8'h08
`define ISC_A_PTX    8'h20
`define ISC_A_PTY    8'h40
`define ISC_NPT_MAX  8'h14
// Field positions
`define ISC_F_MODE   1:0
`define ISC_F_RANGE  2
`define ISC_F_ENTER  0
`define ISC_F_ESCAPE 1
// Conversion modes
`define ISC_M_LIN    2'h0
`define ISC_M_SQR    2'h1
`define ISC_M_ROOT   2'h2
`define ISC_M_USER   2'h3
// Nominal ranges in microamps
`define ISC_START_420 16'h0fa0
`define ISC_START_020 16'h0000
`define ISC_SPAN_420  16'h3e80
`define ISC_SPAN_020  16'h4e20
// Access codes; the service code value is arbitrary
`define ISC_KEY_FACTORY_DEFAULTS_OPTION  16'h1559
`define ISC_KEY_SVC   16'h0a5c
// Factory values
`define ISC_RST_CTRL  3'h4
`define ISC_RST_LOC   16'h0000
`define ISC_RST_HIC   16'h03e8
`define ISC_RST_NPTS  5'h02
`define ISC_RST_XHI   16'h03e8
`define ISC_RST_YHI   16'h03e8
`define ISC_RST_SVC   16'h0000
// Display limits and scale factors
`define ISC_W_MIN     16'hfc19
`define ISC_W_MAX     16'h270f
`define ISC_PCT10     17'h003e8
`define ISC_HALF      64'h0000000000008000
`endif

// file: hdl/isc_fifo.v
// Result FIFO with valid and ready on both sides
module isc_fifo #(
    parameter W  = 16,
    parameter D  = 4,
    parameter AW = 2
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rst_b,
    // Fill side
    input  wire         i_in_valid,
    input  wire [W-1:0] i_in_data,
    output wire         o_in_ready,
    // Drain side
    output wire         o_out_valid,
    output wire [W-1:0] o_out_data,
    input  wire         i_out_ready
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         push;
    wire         pop;

    assign o_in_ready  = (cnt_r != D[AW:0]);
    assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
    assign o_out_data  = mem_r[rp_r];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_r[wp_r] <= i_in_data;
                wp_r        <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // isc_fifo

// file: hdl/isc_sqrt.v
// Sequential integer square root, rounded to nearest
module isc_sqrt #(
    parameter W = 40
) (
    // Clock and reset
    input  wire           i_clk,
    input  wire           i_rst_b,
    // Request
    input  wire           i_start,
    input  wire [W-1:0]   i_rad,
    // Answer
    output reg  [W/2-1:0] o_root,
    output reg            o_done
);
    reg [W-1:0] op_r;
    reg [W-1:0] res_r;
    reg [W-1:0] one_r;
    reg         run_r;
    wire [W-1:0] trial = res_r + one_r;

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            op_r   <= {W{1'b0}};
            res_r  <= {W{1'b0}};
            one_r  <= {W{1'b0}};
            run_r  <= 1'b0;
            o_root <= {(W/2){1'b0}};
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                op_r  <= i_rad;
                res_r <= {W{1'b0}};
                one_r <= {2'b01, {(W-2){1'b0}}};
                run_r <= 1'b1;
            end else if (run_r) begin
                if (one_r == {W{1'b0}}) begin
                    // Round up when the remainder passes the root
                    o_root <= res_r[W/2-1:0] + {{(W/2-1){1'b0}}, (op_r > res_r)};
                    o_done <= 1'b1;
                    run_r  <= 1'b0;
                end else begin
                    if (op_r >= trial) begin
                        op_r  <= op_r - trial;
                        res_r <= (res_r >> 1) + one_r;
                    end else begin
                        res_r <= res_r >> 1;
                    end
                    one_r <= one_r >> 2;
                end
            end
        end
    end
endmodule // isc_sqrt

// file: test/isc_core_monitor.sv
// Port-level assertions for the input scaler
`include "isc_defines.vh"
module isc_core_monitor #(
    parameter SW = 16
) (
    // Clock and reset
    input logic          i_clk,
    input logic          i_rst_b,
    // Register port
    input logic [7:0]    i_addr,
    input logic [15:0]   i_wdata,
    input logic          i_wr,
    input logic          i_rd,
    input logic [15:0]   o_rdata,
    // Sample and result streams
    input logic          i_smp_valid,
    input logic [SW-1:0] i_smp_data,
    input logic          o_smp_ready,
    input logic          o_res_valid,
    input logic [15:0]   o_res_data,
    input logic          i_res_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_reset_quiet: assert property (disable iff (1'b0)
        !i_rst_b |=> !o_res_valid && o_rdata == 16'h0) else $error("Outputs busy after reset");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
        else $error("Read data outside read cycle");
    a_unmapped_zero: assert property (i_rd && i_addr == 8'h10 |=> o_rdata == 16'h0)
        else $error("Unmapped read not zero");
    a_busy_on_take: assert property (i_smp_valid && o_smp_ready |=> !o_smp_ready)
        else $error("Ready stayed high after a sample was taken");
    // Only with an empty result queue, since a full one may stall the converter forever
    a_conv_bounded: assert property (i_smp_valid && o_smp_ready && !o_res_valid
        |-> ##[2:300] o_smp_ready) else $error("Conversion did not finish");
    a_result_range: assert property (o_res_valid |-> $signed(o_res_data) >= -999
        && $signed(o_res_data) <= 9999) else $error("Result outside display range");
    a_result_held: assert property (o_res_valid && !i_res_ready
        |=> o_res_valid && $stable(o_res_data)) else $error("Result changed while stalled");
    a_stat_mirror: assert property (i_rd && i_addr == `ISC_A_STAT
        |=> o_rdata[3] == $past(o_res_valid)) else $error("Status valid bit wrong");
    a_restore_prompt: assert property (i_wr && i_addr == `ISC_A_KEY
        && i_wdata == `ISC_KEY_FACTORY_DEFAULTS_OPTION ##2 i_rd && i_addr == `ISC_A_STAT |=> o_rdata[1])
        else $error("Restore prompt not open after code");
    a_service_shut: assert property (i_wr && i_addr == `ISC_A_KEY
        && i_wdata != `ISC_KEY_SVC ##2 i_rd && i_addr == `ISC_A_STAT |=> !o_rdata[2])
        else $error("Service open without its code");
endmodule // isc_core_monitor

bind isc_core isc_core_monitor #(.SW(SW)) u_isc_core_monitor (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
    .o_smp_ready(o_smp_ready), .o_res_valid(o_res_valid), .o_res_data(o_res_data),
    .i_res_ready(i_res_ready)
);

// file: test/isc_far_model.sv
// Far-side model: measurement source and display consumer
module isc_far_model (
    // Clock
    input  logic        i_clk,
    // Sample source
    output logic        o_smp_valid,
    output logic [15:0] o_smp_data,
    input  logic        i_smp_ready,
    // Result consumer
    input  logic        i_res_valid,
    input  logic [15:0] i_res_data,
    output logic        o_res_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_smp_valid = 1'b0;
        o_smp_data  = 16'h0;
        o_res_ready = 1'b0;
    end
    task send(input logic [15:0] d, output bit ok);
        bit r;
        ok = 0;
        @(posedge i_clk);
        o_smp_valid <= 1'b1;
        o_smp_data  <= d;
        for (int k = 0; k < 400 && !ok; k++) begin
            @(negedge i_clk) r = i_smp_ready;
            @(posedge i_clk);
            ok = r;
        end
        o_smp_valid <= 1'b0;
        // Idle data is scrambled so a stale sample cannot pass for a live one
        o_smp_data  <= ~d;
    endtask
    task take(output logic [15:0] d, output bit ok);
        bit r;
        ok = 0;
        @(posedge i_clk);
        o_res_ready <= 1'b1;
        for (int k = 0; k < 400 && !ok; k++) begin
            @(negedge i_clk) r = i_res_valid;
            d = i_res_data;
            @(posedge i_clk);
            ok = r;
        end
        o_res_ready <= 1'b0;
    endtask
endmodule // isc_far_model

// file: test/isc_core_tb.sv
// Self-checking bench for the input scaler
`include "isc_defines.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== 16'(e)) begin err_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, 16'(e)); end end
module isc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rst_b, i_wr, i_rd;
    logic [7:0]  i_addr;
    logic [15:0] i_wdata, o_rdata, smp_data, res_data, rv;
    logic        smp_valid, smp_ready, res_valid, res_ready;
    int          err_count = 0;
    int          n_checks = 0;
    bit          ok;

    isc_core #(.SW(16), .FD(4)) u_isc_core (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_valid(smp_valid), .i_smp_data(smp_data),
        .o_smp_ready(smp_ready), .o_res_valid(res_valid), .o_res_data(res_data),
        .i_res_ready(res_ready));
    isc_far_model u_isc_far_model (
        .i_clk(i_clk), .o_smp_valid(smp_valid), .o_smp_data(smp_data),
        .i_smp_ready(smp_ready), .i_res_valid(res_valid), .i_res_data(res_data),
        .o_res_ready(res_ready));

    task automatic conclude;
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        `CHK(o_rdata, e)
    endtask
    task automatic conv(input logic [15:0] s, input logic [15:0] e);
        u_isc_far_model.send(s, ok);
        if (ok) begin
            u_isc_far_model.take(rv, ok);
        end
        if (!ok) begin
            err_count++;
            conclude();
        end else begin
            `CHK(rv, e)
        end
    endtask
    task automatic t_curves;
        logic [15:0] smp [3] = '{16'h09c4, 16'h2710, 16'h5014};
        int          w [3][3] = '{'{-441, 263, 1247}, '{-287, -89, 1295}, '{-300, 619, 1223}};
        wr(`ISC_A_LOC, 16'hfed4);
        wr(`ISC_A_HIC, 16'h04b0);
        for (int m = 0; m < 3; m++) begin
            wr(`ISC_A_CTRL, 16'h4 | 16'(m));
            for (int k = 0; k < 3; k++) begin
                conv(smp[k], 16'(w[m][k]));
            end
        end
    endtask
    task automatic t_invert_clamp;
        wr(`ISC_A_LOC, 16'h04b0);
        wr(`ISC_A_HIC, 16'hfed4);
        wr(`ISC_A_CTRL, 16'h4);
        conv(16'h09c4, 16'd1341);
        wr(`ISC_A_LOC, 16'hfed4);
        wr(`ISC_A_HIC, 16'h04b0);
        wr(`ISC_A_CTRL, 16'h0);
        conv(16'h2710, 16'd450);
        wr(`ISC_A_LOC, `ISC_W_MIN);
        wr(`ISC_A_HIC, `ISC_W_MAX);
        wr(`ISC_A_CTRL, 16'h4);
        conv(16'h09c4, `ISC_W_MIN);
        conv(16'h5014, `ISC_W_MAX);
        rchk(`ISC_A_LAST, `ISC_W_MAX);
    endtask
    task automatic t_user;
        logic [15:0] x [4] = '{16'd0, 16'd100, 16'd300, 16'd400};
        logic [15:0] y [4] = '{16'hffce, 16'hffe2, 16'h001e, 16'h0050};
        wr(`ISC_A_NPTS, 16'd25);
        rchk(`ISC_A_NPTS, 16'h14);
        wr(`ISC_A_NPTS, 16'h4);
        for (int k = 0; k < 4; k++) begin
            wr(8'(`ISC_A_PTX + k), x[k]);
            wr(8'(`ISC_A_PTY + k), y[k]);
        end
        wr(`ISC_A_CTRL, 16'h7);
        conv(16'h09c4, 16'hffbb);
        conv(16'h2710, 16'd68);
        conv(16'h5014, 16'd396);
    endtask
    // Consumer stalls while five samples go in; the fifth must wait in the converter
    task automatic t_fifo;
        wr(`ISC_A_LOC, 16'h0);
        wr(`ISC_A_HIC, 16'h03e8);
        wr(`ISC_A_CTRL, 16'h4);
        for (int k = 1; k < 6; k++) begin
            u_isc_far_model.send(16'(4000 + 1600 * k), ok);
            `CHK(16'(ok), 16'h1)
        end
        repeat (200) @(posedge i_clk);
        `CHK(16'(smp_ready), 16'h0)
        rchk(`ISC_A_STAT, 16'h9);
        for (int k = 1; k < 6; k++) begin
            u_isc_far_model.take(rv, ok);
            `CHK(rv, 100 * k)
        end
    endtask
    task automatic t_access;
        wr(`ISC_A_SVC, 16'h5);
        rchk(`ISC_A_SVC, 16'h0);
        wr(`ISC_A_KEY, `ISC_KEY_SVC);
        wr(`ISC_A_SVC, 16'h5);
        rchk(`ISC_A_SVC, 16'h5);
        wr(`ISC_A_KEY, 16'h0);
        rchk(`ISC_A_STAT, 16'h0);
        wr(`ISC_A_LOC, 16'h0123);
        wr(`ISC_A_CMD, 16'h1);
        rchk(`ISC_A_LOC, 16'h0123);
        wr(`ISC_A_KEY, `ISC_KEY_FACTORY_DEFAULTS_OPTION);
        rchk(`ISC_A_STAT, 16'h2);
        wr(`ISC_A_CMD, 16'h2);
        rchk(`ISC_A_LOC, 16'h0123);
        wr(`ISC_A_KEY, `ISC_KEY_FACTORY_DEFAULTS_OPTION);
        wr(`ISC_A_CMD, 16'h1);
        rchk(`ISC_A_LOC, `ISC_RST_LOC);
        rchk(`ISC_A_HIC, `ISC_RST_HIC);
        rchk(`ISC_A_SVC, `ISC_RST_SVC);
        rchk(`ISC_A_NPTS, `ISC_RST_NPTS);
        rchk(`ISC_A_CTRL, `ISC_RST_CTRL);
        rchk(8'(`ISC_A_PTX + 1), `ISC_RST_XHI);
        rchk(8'(`ISC_A_PTY + 1), `ISC_RST_YHI);
        rchk(`ISC_A_STAT, 16'h0);
        rchk(8'h10, 16'h0);
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        i_rst_b = 1'b0;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        i_addr  = 8'h0;
        i_wdata = 16'h0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rchk(`ISC_A_CTRL, `ISC_RST_CTRL);
        rchk(`ISC_A_HIC, `ISC_RST_HIC);
        t_curves();
        t_invert_clamp();
        t_user();
        t_fifo();
        t_access();
        conclude();
    end
    // A hang anywhere ends the run through the same report
    initial begin
        #200us;
        err_count++;
        conclude();
    end
endmodule // isc_core_tb
